// ### logic/flash_write_qualify.sv
// write cycle qualification, power-up and lockout inhibit, sector decode
`timescale 1ns/1ps
module flash_write_qualify
	import flash_front_pkg::*;
(
	input  wire logic                            clk_sys,
	input  wire logic                            reset,
	input  wire flash_front_pkg::strobes_t       strobes,
	input  wire logic [flash_front_pkg::ADDR_W-1:0] addr,
	input  wire logic                            mode_x32,
	input  wire logic                            reset_pin_n,
	input  wire logic                            supply_lockout_level,
	output logic                                 write_pulse,
	output logic [flash_front_pkg::ADDR_W-1:0]   write_addr,
	output flash_front_pkg::sector_info_t        write_sector,
	output logic                                 write_active,
	output logic                                 cmd_enable,
	output logic                                 array_read
);
	// ==================================================
	// input synchronisers
	// pulses shorter than one clock may be missed; no glitch
	// filter here, that is left to the pad cells
	strobes_t          strb_s1_q;
	strobes_t          strb_s2_q;
	logic [ADDR_W-1:0] addr_s1_q;
	logic [ADDR_W-1:0] addr_s2_q;
	logic [2:0]        lvl_s1_q;
	logic [2:0]        lvl_s2_q;
	logic              rst_pin_n_s;
	logic              lockout_s;
	logic              x32_s;

	// strobes park idle, so no write is seen out of reset
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			strb_s1_q <= '1;
			strb_s2_q <= '1;
		end
		else
		begin
			strb_s1_q <= strobes;
			strb_s2_q <= strb_s1_q;
		end
	end

	// address is not gray coded: the host must hold it steady
	// from before the strobes fall until they rise again
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			addr_s1_q <= '0;
			addr_s2_q <= '0;
		end
		else
		begin
			addr_s1_q <= addr;
			addr_s2_q <= addr_s1_q;
		end
	end

	// levels leave reset as locked out, so the machine passes
	// through the lockout state before it takes any write
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			lvl_s1_q <= LVL_RESET;
			lvl_s2_q <= LVL_RESET;
		end
		else
		begin
			lvl_s1_q <= {mode_x32, reset_pin_n, supply_lockout_level};
			lvl_s2_q <= lvl_s1_q;
		end
	end

	assign {x32_s, rst_pin_n_s, lockout_s} = lvl_s2_q;

	// ==================================================
	// write qualification
	logic wr_cond;
	logic inhibit;

	assign wr_cond = !strb_s2_q.ce_n && !strb_s2_q.we_n && strb_s2_q.oe_n;
	// reset pin held through ramp
	// reset pin low is handled exactly like lockout
	assign inhibit = lockout_s || !rst_pin_n_s;

	// ==================================================
	// command state machine
	cmd_state_t        st_q;
	cmd_state_t        st_d;
	logic              act_q;
	logic              act_d;
	logic              pulse_q;
	logic              pulse_d;
	logic [ADDR_W-1:0] waddr_q;
	logic [ADDR_W-1:0] waddr_d;
	sector_info_t      wsec_q;
	sector_info_t      wsec_d;
	sector_info_t      dec_info;

	sector_decode u_decode
	(
		.addr     (addr_s2_q),
		.mode_x32 (x32_s),
		.info     (dec_info)
	);

	always_comb
	begin
		st_d    = st_q;
		act_d   = act_q;
		pulse_d = 1'b0;
		waddr_d = waddr_q;
		wsec_d  = wsec_q;
		case (st_q)
			CMD_ARRAY_READ:
			begin
				// no command from strobes held at power-up
				// strobes must leave the write state first
				if (inhibit)
					st_d = CMD_LOCKED;
				else if (!wr_cond)
					st_d = CMD_ACCEPT;
			end
			CMD_ACCEPT:
			begin
				if (inhibit)
				begin
					// a write cut by lockout gives no pulse
					st_d  = CMD_LOCKED;
					act_d = 1'b0;
				end
				else if (wr_cond && !act_q)
				begin
					// address and sector held until next start
					act_d   = 1'b1;
					waddr_d = addr_s2_q;
					wsec_d  = dec_info;
				end
				else if (!wr_cond && act_q)
				begin
					// command taken on write strobe release
					act_d   = 1'b0;
					pulse_d = 1'b1;
				end
			end
			CMD_LOCKED:
			begin
				// any write caught here is simply dropped
				act_d = 1'b0;
				if (!inhibit)
					st_d = CMD_ARRAY_READ;
			end
			default:
				st_d = CMD_ARRAY_READ;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			st_q    <= CMD_ARRAY_READ;
			act_q   <= 1'b0;
			pulse_q <= 1'b0;
			waddr_q <= '0;
			wsec_q  <= '0;
		end
		else
		begin
			st_q    <= st_d;
			act_q   <= act_d;
			pulse_q <= pulse_d;
			waddr_q <= waddr_d;
			wsec_q  <= wsec_d;
		end
	end

	// ==================================================
	// registered outputs
	// every output is a flop, in step with the machine state
	logic en_q;
	logic en_d;
	logic rd_q;
	logic rd_d;

	always_comb
	begin
		en_d = (st_d == CMD_ACCEPT);
		// array read unless a write is under way
		rd_d = (st_d != CMD_ACCEPT) || !act_d;
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			en_q <= 1'b0;
			rd_q <= 1'b1;
		end
		else
		begin
			en_q <= en_d;
			rd_q <= rd_d;
		end
	end

	assign write_pulse  = pulse_q;
	assign write_addr   = waddr_q;
	assign write_sector = wsec_q;
	assign write_active = act_q;
	assign cmd_enable   = en_q;
	assign array_read   = rd_q;
endmodule

// ### logic/flash_front_pkg.sv
// constants and types for the flash write qualifier and sector decoder
package flash_front_pkg;

	localparam int ADDR_W = 20;
	localparam int SECT_W = 6;
	localparam int GRP_W  = 4;

	// small boot sectors: 4 Kwords, x16 span 1000h, x32 span 800h
	localparam int SMALL_SHIFT_X16 = 12;
	localparam int SMALL_SHIFT_X32 = 11;
	// main sectors: 32 Kwords, x16 span 8000h, x32 span 4000h
	localparam int MAIN_SHIFT_X16  = 15;
	localparam int MAIN_SHIFT_X32  = 14;
	// eight small sectors sit below the first main sector
	localparam logic [ADDR_W-1:0] BOOT_END_X16 = 20'h07fff;
	localparam logic [ADDR_W-1:0] BOOT_END_X32 = 20'h03fff;
	localparam logic [SECT_W-1:0] FIRST_MAIN_SECTOR = 6'h08;
	localparam logic [SECT_W-1:0] SMALL_PER_GROUP   = 6'h04;
	localparam logic [GRP_W-1:0]  FIRST_MAIN_GROUP  = 4'h2;
	// synced {mode_x32, reset pin, lockout} at reset: locked out
	localparam logic [2:0]        LVL_RESET         = 3'h1;

	typedef enum logic [1:0] {
		CMD_ARRAY_READ,
		CMD_ACCEPT,
		CMD_LOCKED
	} cmd_state_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
	} strobes_t;

	typedef struct packed {
		logic [SECT_W-1:0] sector;
		logic [GRP_W-1:0]  group;
		logic              boot_small;
	} sector_info_t;

endpackage

// ### logic/sector_decode.sv
// word address to sector and sector group decoder
`timescale 1ns/1ps
module sector_decode
	import flash_front_pkg::*;
(
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              mode_x32,
	output sector_info_t           info
);
	logic [ADDR_W-1:0] boot_end;
	logic [SECT_W-1:0] sec;

	always_comb
	begin
		boot_end = mode_x32 ? BOOT_END_X32 : BOOT_END_X16;
		info = '0;
		if (addr <= boot_end)
		begin
			if (mode_x32)
				sec = SECT_W'(addr >> SMALL_SHIFT_X32);
			else
				sec = SECT_W'(addr >> SMALL_SHIFT_X16);
			info.boot_small = 1'b1;
			info.sector = sec;
			info.group = GRP_W'(sec / SMALL_PER_GROUP);
		end
		else
		begin
			if (mode_x32)
				sec = SECT_W'(addr >> MAIN_SHIFT_X32);
			else
				sec = SECT_W'(addr >> MAIN_SHIFT_X16);
			info.sector = sec - SECT_W'(1) + FIRST_MAIN_SECTOR;
			info.group = GRP_W'(info.sector - FIRST_MAIN_SECTOR)
				+ FIRST_MAIN_GROUP;
		end
	end
endmodule

// ### testbench/flash_write_qualify_asserts.sv
// port checks for the flash write qualifier
`timescale 1ns/1ps
module flash_write_qualify_asserts
	import flash_front_pkg::*;
(
	input wire logic                        clk_sys,
	input wire logic                        reset,
	input wire flash_front_pkg::strobes_t   strobes,
	input wire logic                        supply_lockout_level,
	input wire logic                        write_pulse,
	input wire logic [ADDR_W-1:0]           write_addr,
	input wire logic                        write_active,
	input wire logic                        cmd_enable,
	input wire logic                        array_read
);
	// ==========
	// properties
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_idle; (strobes != 3'b010)[*3] |=> !write_active; endproperty
	property p_start; $rose(write_active) |-> $past(strobes, 2) == 3'b010;
	endproperty
	property p_pulse; write_pulse |-> $past(write_active) && cmd_enable;
	endproperty
	property p_one; write_pulse |=> !write_pulse; endproperty
	property p_armed; $rose(write_active) |-> $past(cmd_enable);
	endproperty
	property p_lock; supply_lockout_level[*5] |=>
		!cmd_enable && !write_pulse && !write_active; endproperty
	property p_boot; $past(reset) |-> array_read && !write_active; endproperty
	property p_excl; write_active |-> !array_read; endproperty
	property p_hold; !$rose(write_active) |-> $stable(write_addr); endproperty
	a_idle: assert property (p_idle) else $error("write without strobes");
	a_start: assert property (p_start) else $error("bad start");
	a_pulse: assert property (p_pulse) else $error("stray pulse");
	a_armed: assert property (p_armed) else $error("write unarmed");
	a_one: assert property (p_one) else $error("pulse too long");
	a_lock: assert property (p_lock) else $error("lockout leak");
	a_boot: assert property (p_boot) else $error("not array read");
	a_excl: assert property (p_excl) else $error("read during write");
	a_hold: assert property (p_hold) else $error("address moved");
	c_write: cover property (write_pulse);
	c_lock: cover property (supply_lockout_level && strobes == 3'b010);
	c_boot: cover property ($past(reset) && strobes == 3'b010);
endmodule
bind flash_write_qualify flash_write_qualify_asserts u_chk (.*);

// ### testbench/flash_host_model.sv
// host controller model driving the flash strobes
`timescale 1ns/1ps
module flash_host_model
	import flash_front_pkg::*;
(
	input  wire logic                   clk_sys,
	output flash_front_pkg::strobes_t   strobes,
	output logic [ADDR_W-1:0]           addr
);
	initial strobes = 3'b111;
	initial addr = '0;
	task automatic put(input strobes_t s, input logic [ADDR_W-1:0] a);
		@(posedge clk_sys);
		#1 strobes = s;
		addr = a;
	endtask
	task automatic cyc(input strobes_t s, input logic [ADDR_W-1:0] a, int n);
		put(s, a);
		repeat (n) @(posedge clk_sys);
		put(3'b111, ~a);
		repeat (3) @(posedge clk_sys);
	endtask
endmodule

// ### testbench/tb_flash_write_qualify.sv
// self-checking bench for the flash write qualifier
`timescale 1ns/1ps
module tb_flash_write_qualify;
	import flash_front_pkg::*;
	logic              clk_sys, reset, mode_x32, reset_pin_n, m;
	logic              supply_lockout_level, write_pulse, write_active;
	logic              cmd_enable, array_read;
	strobes_t          strobes;
	strobes_t          inh[3] = '{3'b110, 3'b000, 3'b011};
	logic [ADDR_W-1:0] addr, write_addr;
	sector_info_t      write_sector;
	logic [30:0]       note_q[$];
	int                n_mismatch = 0;
	int                cmp_count = 0;
	flash_host_model u_host (.*);
	flash_write_qualify u_dut (.*);
	initial
	begin
		clk_sys = 0;
		forever #20 clk_sys = ~clk_sys;
	end
	task chk(input string what, input logic [30:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", what, e, g);
		end
	endtask
	function automatic logic [30:0] ex(logic [19:0] a, logic x);
		logic [19:0] s;
		logic        b;
		b = x ? a < 20'h04000 : a < 20'h08000;
		s = x ? (b ? a >> 11 : a >> 14) : (b ? a >> 12 : a >> 15);
		if (b)
			return {a, s[5:0], s[5:2], 1'b1};
		return {a, s[5:0] + 6'h07, s[3:0] + 4'h1, 1'b0};
	endfunction
	task summarize;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(negedge clk_sys)
		if (write_pulse === 1'b1)
			chk("write", note_q.size() ? note_q.pop_front() : 'x,
				{write_addr, write_sector});
	task wr(input strobes_t s, input logic [19:0] a, input logic x);
		@(posedge clk_sys);
		#1 mode_x32 = x;
		if (s == 3'b010 && !supply_lockout_level && reset_pin_n)
			note_q.push_back(ex(a, x));
		u_host.cyc(s, a, 2 + $urandom % 4);
	endtask
	initial
	begin
		void'($urandom(32'h094d));
		reset = 1;
		mode_x32 = 0;
		reset_pin_n = 0;
		supply_lockout_level = 0;
		u_host.put(3'b010, 20'h0);
		repeat (19) @(posedge clk_sys);
		// pin released with the ramp done
		#1 reset = 0;
		reset_pin_n = 1;
		repeat (6) @(posedge clk_sys);
		u_host.put(3'b111, 20'h0);
		for (int i = 0; i < 3; i++)
			wr(inh[i], 20'h01234, 0);
		wr(3'b010, 20'h07fff, 0);
		wr(3'b010, 20'h08000, 0);
		wr(3'b010, 20'h10000, 0);
		wr(3'b010, 20'h03fff, 1);
		wr(3'b010, 20'h04000, 1);
		repeat (12)
		begin
			m = 1'($urandom % 2);
			wr(3'b010, 20'($urandom % (m ? 20'h30000 : 20'h60000)), m);
		end
		#1 supply_lockout_level = 1;
		repeat (6) @(posedge clk_sys);
		wr(3'b010, 20'h02000, 0);
		#1 supply_lockout_level = 0;
		repeat (6) @(posedge clk_sys);
		wr(3'b010, 20'h02000, 0);
		#1 reset_pin_n = 0;
		repeat (6) @(posedge clk_sys);
		wr(3'b010, 20'h03000, 0);
		#1 reset_pin_n = 1;
		repeat (6) @(posedge clk_sys);
		wr(3'b010, 20'h03000, 0);
		repeat (8) @(posedge clk_sys);
		chk("left", 31'h0, 31'(note_q.size()));
		summarize();
	end
	initial
	begin
		#(40 * 4000);
		n_mismatch++;
		summarize();
	end
endmodule
